/* File: inc/odt_defines.svh */
// Timing and range constants for the on/off delay timer block
`ifndef ODT_DEFINES_SVH
`define ODT_DEFINES_SVH
`define ODT_CLK_HZ        25000000
`define ODT_TICK_MS       10
`define ODT_TICK_CYC      ((`ODT_CLK_HZ / 1000) * `ODT_TICK_MS)
`define ODT_PAR_S_MAX     16'h270f
`define ODT_PAR_HI_MAX    16'h0063
`define ODT_PAR_MINSEC    16'h003b
`define ODT_BASE60        32'h0000003c
`define ODT_REF_MS_MAX    17'h18696
`define ODT_REF_SM_MAX    17'h176f
`define ODT_TICKS_PER_S   32'h00000064
`define ODT_TICKS_PER_M   32'h00001770
`define ODT_TICKS_PER_H   32'h00057e40
`define ODT_MS_PER_TICK   17'h0000a
`endif

/* File: inc/odt_pkg.sv */
// Types shared by the on/off delay timer block
package odt_pkg;
   typedef enum logic [1:0] {
      ODT_TB_S = 2'b00,
      ODT_TB_M = 2'b01,
      ODT_TB_H = 2'b10
   } odt_tb_e;
   typedef enum logic [1:0] {
      ODT_IDLE = 2'b00,
      ODT_RUN  = 2'b01,
      ODT_DONE = 2'b10
   } odt_state_e;
endpackage : odt_pkg

/* File: rtl/odt_timer.sv */
// On-delay / off-delay timer with fixed or referenced preset
// Operation
// - On-delay: rising trigger starts elapsed count from zero.
// - On-delay: output rises when elapsed count reaches preset while trigger high.
// - On-delay: trigger falling before preset clears elapsed count.
// - On-delay: output low whenever trigger is low.
// - Fixed preset: seconds to 99:99 at 10 ms; minutes, hours to 99:59.
// - Referenced preset: ms up to 99990, seconds or minutes up to 5999.
// - Out-of-range referenced preset is clamped to nearest valid value.
// - Preset may come from another block's live value, timebase chosen separately.
// - Off-delay: output rises at once when trigger goes high.
// - Off-delay: falling trigger restarts elapsed count, output stays high.
// - Off-delay: output falls when elapsed count reaches preset.
// - Off-delay: new trigger pulse restarts count, postponing expiry.
// - Off-delay: reset input clears elapsed count and output.
// - Retentive option keeps timer state instead of clearing it.
`timescale 1ns/100ps
`include "odt_defines.svh"
module odt_timer
   import odt_pkg::*;
#(
   parameter int TICK_CYC = `ODT_TICK_CYC
) (
   input  wire logic        ref_clk,
   input  wire logic        rst,
   input  wire logic        restart,
   input  wire logic        off_mode,
   input  wire logic        retentive,
   input  wire logic        trg,
   input  wire logic        tmr_reset,
   input  wire logic        use_ref,
   input  wire logic [1:0]  timebase,
   input  wire logic [15:0] par_hi,
   input  wire logic [15:0] par_lo,
   input  wire logic [31:0] ref_value,
   output logic             q,
   output logic [31:0]      elapsed_count,
   output logic             tick
);
   logic [31:0] tick_cnt_q;
   logic        trg_q;
   logic [31:0] elapsed_q;
   logic        q_q;
   logic        tick_q;
   odt_state_e  st_q;

   wire         tick_now = (tick_cnt_q == 32'(TICK_CYC - 1));
   wire         rise     = trg & ~trg_q;
   wire         fall     = ~trg & trg_q;
   // Module restart clears state unless retentive
   wire         clr_all  = restart & ~retentive;

   // Fixed preset: hi:lo, seconds field is hundredths, others are minutes/seconds
   wire [7:0]   hi_c     = (par_hi > `ODT_PAR_HI_MAX) ? 8'(`ODT_PAR_HI_MAX) : par_hi[7:0];
   wire [7:0]   lo_s     = (par_lo > `ODT_PAR_HI_MAX) ? 8'(`ODT_PAR_HI_MAX) : par_lo[7:0];
   wire [7:0]   lo_m     = (par_lo > `ODT_PAR_MINSEC) ? 8'(`ODT_PAR_MINSEC) : par_lo[7:0];
   wire [31:0]  fix_s    = 32'(hi_c) * `ODT_TICKS_PER_S + 32'(lo_s);
   wire [31:0]  fix_m    = (32'(hi_c) * `ODT_BASE60 + 32'(lo_m)) * `ODT_TICKS_PER_S;
   wire [31:0]  fix_h    = (32'(hi_c) * `ODT_BASE60 + 32'(lo_m)) * `ODT_TICKS_PER_M;

   // Referenced preset clamped, negatives to zero
   wire         ref_neg  = ref_value[31];
   wire [31:0]  ref_ms   = ref_neg ? 32'h0 :
                           (ref_value > 32'(`ODT_REF_MS_MAX)) ? 32'(`ODT_REF_MS_MAX) :
                           ref_value;
   wire [31:0]  ref_sm   = ref_neg ? 32'h0 :
                           (ref_value > 32'(`ODT_REF_SM_MAX)) ? 32'(`ODT_REF_SM_MAX) :
                           ref_value;
   wire [31:0]  ref_tk   = (timebase == ODT_TB_S) ? ref_ms / 32'(`ODT_MS_PER_TICK) :
                           (timebase == ODT_TB_M) ? ref_sm * `ODT_TICKS_PER_S :
                           ref_sm * `ODT_TICKS_PER_M;
   wire [31:0]  fix_tk   = (timebase == ODT_TB_S) ? fix_s :
                           (timebase == ODT_TB_M) ? fix_m : fix_h;
   wire [31:0]  preset   = use_ref ? ref_tk : fix_tk;
   wire         reached  = (elapsed_q >= preset);

   // Next-state of the elapsed counter and output
   logic [31:0] elapsed_d;
   logic        q_d;
   odt_state_e  st_d;
   always_comb begin
      elapsed_d = elapsed_q;
      q_d       = q_q;
      st_d      = st_q;
      if (!off_mode) begin
         case (st_q)
            ODT_IDLE: begin
               q_d = 1'b0;
               if (rise) begin
                  elapsed_d = 32'h0;
                  st_d      = ODT_RUN;
               end
            end
            ODT_RUN: begin
               if (!trg) begin
                  elapsed_d = 32'h0;
                  st_d      = ODT_IDLE;
               end else if (reached) begin
                  q_d  = 1'b1;
                  st_d = ODT_DONE;
               end else if (tick_now) begin
                  elapsed_d = elapsed_q + 32'h1;
               end
            end
            ODT_DONE: begin
               if (!trg) begin
                  q_d  = 1'b0;
                  st_d = ODT_IDLE;
               end
            end
            default: st_d = ODT_IDLE;
         endcase
         if (!trg) q_d = 1'b0;
      end else begin
         case (st_q)
            ODT_IDLE: begin
               if (trg) begin
                  q_d  = 1'b1;
                  st_d = ODT_DONE;
               end
            end
            ODT_DONE: begin
               q_d = 1'b1;
               if (fall) begin
                  elapsed_d = 32'h0;
                  st_d      = ODT_RUN;
               end
            end
            ODT_RUN: begin
               // Output held high for the whole run, even if entered after a mode change
               q_d = 1'b1;
               if (trg) begin
                  elapsed_d = 32'h0;
                  st_d      = ODT_DONE;
               end else if (reached) begin
                  q_d  = 1'b0;
                  st_d = ODT_IDLE;
               end else if (tick_now) begin
                  elapsed_d = elapsed_q + 32'h1;
               end
            end
            default: st_d = ODT_IDLE;
         endcase
         if (tmr_reset) begin
            elapsed_d = 32'h0;
            q_d       = 1'b0;
            st_d      = ODT_IDLE;
         end
      end
      if (clr_all) begin
         elapsed_d = 32'h0;
         q_d       = 1'b0;
         st_d      = ODT_IDLE;
      end
   end

   // Prescaler free-runs: the first interval after a trigger may be up to one tick short
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         tick_cnt_q <= 32'h0;
         tick_q     <= 1'b0;
      end else begin
         tick_cnt_q <= tick_now ? 32'h0 : tick_cnt_q + 32'h1;
         tick_q     <= tick_now;
      end
   end

   // Trigger history survives a module restart so a retained timer sees no false edge
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         trg_q     <= 1'b0;
         elapsed_q <= 32'h0;
         q_q       <= 1'b0;
         st_q      <= ODT_IDLE;
      end else begin
         trg_q     <= trg;
         elapsed_q <= elapsed_d;
         q_q       <= q_d;
         st_q      <= st_d;
      end
   end

   assign q             = q_q;
   assign elapsed_count = elapsed_q;
   assign tick          = tick_q;

   property p_on_low;
      @(posedge ref_clk) disable iff (rst) (!off_mode && !trg) |=> !q_q;
   endproperty
   a_on_low: assert property (p_on_low) else $error("on-delay output high with trigger low");

   property p_on_rise_clear;
      @(posedge ref_clk) disable iff (rst)
         (!off_mode && st_q == ODT_IDLE && rise && !clr_all) |=> (elapsed_q == 32'h0);
   endproperty
   a_on_rise_clear: assert property (p_on_rise_clear) else $error("count not zeroed on rise");

   property p_on_fire;
      @(posedge ref_clk) disable iff (rst)
         (!off_mode && st_q == ODT_RUN && trg && reached && !clr_all) |=> q_q;
   endproperty
   a_on_fire: assert property (p_on_fire) else $error("on-delay did not fire");

   property p_on_abort;
      @(posedge ref_clk) disable iff (rst)
         (!off_mode && st_q == ODT_RUN && !trg) |=> (elapsed_q == 32'h0 && !q_q);
   endproperty
   a_on_abort: assert property (p_on_abort) else $error("count kept after early fall");

   property p_off_set;
      @(posedge ref_clk) disable iff (rst)
         (off_mode && trg && !tmr_reset && !clr_all) |=> q_q;
   endproperty
   a_off_set: assert property (p_off_set) else $error("off-delay not set at once");

   property p_off_fall;
      @(posedge ref_clk) disable iff (rst)
         (off_mode && st_q == ODT_DONE && fall && !tmr_reset && !clr_all)
         |=> (q_q && elapsed_q == 32'h0);
   endproperty
   a_off_fall: assert property (p_off_fall) else $error("off-delay fall not restarted");

   property p_off_expire;
      @(posedge ref_clk) disable iff (rst)
         (off_mode && st_q == ODT_RUN && !trg && reached && !tmr_reset) |=> !q_q;
   endproperty
   a_off_expire: assert property (p_off_expire) else $error("off-delay did not expire");

   property p_off_reset;
      @(posedge ref_clk) disable iff (rst)
         (off_mode && tmr_reset) |=> (!q_q && elapsed_q == 32'h0);
   endproperty
   a_off_reset: assert property (p_off_reset) else $error("reset input ignored");

   property p_restart;
      @(posedge ref_clk) disable iff (rst)
         clr_all |=> (!q_q && elapsed_q == 32'h0);
   endproperty
   a_restart: assert property (p_restart) else $error("restart did not clear");

   property p_retain;
      @(posedge ref_clk) disable iff (rst)
         (restart && retentive && !trg && !tmr_reset && st_q == ODT_DONE && off_mode) |=> q_q;
   endproperty
   a_retain: assert property (p_retain) else $error("retentive state lost");

   property p_tick;
      @(posedge ref_clk) disable iff (rst) tick_q |=> !tick_q;
   endproperty
   a_tick: assert property (p_tick) else $error("tick wider than one cycle");

   property p_off_retrig;
      @(posedge ref_clk) disable iff (rst)
         (off_mode && st_q == ODT_RUN && trg && !tmr_reset && !clr_all)
         |=> (q_q && elapsed_q == 32'h0);
   endproperty
   a_off_retrig: assert property (p_off_retrig) else $error("retrigger did not restart");

   property p_off_hold;
      @(posedge ref_clk) disable iff (rst)
         (off_mode && st_q == ODT_RUN && !trg && !reached && !tmr_reset && !clr_all) |=> q_q;
   endproperty
   a_off_hold: assert property (p_off_hold) else $error("off-delay dropped early");

   // An out-of-range source must never push the millisecond preset past its limit of 99990
   property p_ref_clamp;
      @(posedge ref_clk) disable iff (rst)
         (!ref_neg && ref_value > 32'(`ODT_REF_MS_MAX)) |-> (ref_ms == 32'(`ODT_REF_MS_MAX));
   endproperty
   a_ref_clamp: assert property (p_ref_clamp) else $error("referenced preset not clamped");

   property p_ref_floor;
      @(posedge ref_clk) disable iff (rst) ref_neg |-> (ref_ms == 32'h0 && ref_sm == 32'h0);
   endproperty
   a_ref_floor: assert property (p_ref_floor) else $error("negative preset not floored");

   property p_fix_clamp;
      @(posedge ref_clk) disable iff (rst)
         (par_lo > `ODT_PAR_HI_MAX)
         |-> (lo_s == 8'(`ODT_PAR_HI_MAX) && lo_m == 8'(`ODT_PAR_MINSEC));
   endproperty
   a_fix_clamp: assert property (p_fix_clamp) else $error("fixed preset field not clamped");

   // Count may only clear or step by one on a tick
   property p_count_step;
      @(posedge ref_clk) disable iff (rst)
         (elapsed_d != elapsed_q)
         |-> (elapsed_d == 32'h0 || (tick_now && elapsed_d == elapsed_q + 32'h1));
   endproperty
   a_count_step: assert property (p_count_step) else $error("elapsed count jumped");

   property p_rst_clear;
      @(posedge ref_clk) rst |=> (!q_q && elapsed_q == 32'h0 && !tick_q);
   endproperty
   a_rst_clear: assert property (p_rst_clear) else $error("reset did not clear");

   // Main scenarios to be reached by the bench

   c_on_fire:  cover property (@(posedge ref_clk) !off_mode && $rose(q_q));
   c_off_exp:  cover property (@(posedge ref_clk) off_mode && $fell(q_q) && !tmr_reset);
   c_retrig:   cover property (@(posedge ref_clk) off_mode && st_q == ODT_RUN && trg);
   c_ref_clmp: cover property (@(posedge ref_clk) use_ref && ref_value > 32'(`ODT_REF_MS_MAX));
   c_on_abrt:  cover property (@(posedge ref_clk) !off_mode && st_q == ODT_RUN && !trg);
endmodule : odt_timer

/* File: test/odt_src_model.sv */
// Model of the block whose live value feeds the referenced preset
`timescale 1ns/100ps
module odt_src_model (
   input  wire logic        ref_clk,
   input  wire logic        rst,
   input  wire logic [31:0] src_val,
   output logic [31:0]      ref_value
);
   // Live value is republished every cycle, like a running block output
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         ref_value <= 32'h0;
      end else begin
         ref_value <= src_val;
      end
   end
endmodule : odt_src_model

/* File: test/on_off_delay_timers_tb.sv */
// Self-checking bench for the on/off delay timer
`timescale 1ns/100ps
module on_off_delay_timers_tb;
   import odt_pkg::*;
   localparam int TC = 4;
   logic        ref_clk, rst, restart, off_mode, retentive, trg, tmr_reset, use_ref, q, tick;
   logic [1:0]  timebase;
   logic [15:0] par_hi, par_lo;
   logic [31:0] ref_value, src_val, elapsed_count, lfsr;
   int          fail_count, checked, n, pc;
   logic        exp_tick;
   int          c_r[8]  = '{0, 0, 0, 0, 1, 1, 1, 1};
   int          c_tb[8] = '{0, 0, 1, 2, 0, 2, 1, 0};
   int          c_hi[8] = '{1, 0, 0, 0, 0, 0, 0, 0};
   int          c_lo[8] = '{0, 150, 1, 0, 0, 0, 0, 0};
   int          c_v[8]  = '{0, 0, 0, 0, 30, -40, 1, 120000};
   odt_src_model u_src (.ref_clk(ref_clk), .rst(rst), .src_val(src_val), .ref_value(ref_value));
   odt_timer #(.TICK_CYC(TC)) u_dut (.ref_clk(ref_clk), .rst(rst), .restart(restart),
      .off_mode(off_mode), .retentive(retentive), .trg(trg), .tmr_reset(tmr_reset),
      .use_ref(use_ref), .timebase(timebase), .par_hi(par_hi), .par_lo(par_lo),
      .ref_value(ref_value), .q(q), .elapsed_count(elapsed_count), .tick(tick));
   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end
   function automatic int preset(input int r, input int tb, input int hi, input int lo,
                                 input int v);
      if (r) begin
         v = (v < 0) ? 0 : v;
         if (tb == 0) return ((v > 99990) ? 99990 : v) / 10;
         v = (v > 5999) ? 5999 : v;
         return (tb == 1) ? v * 100 : v * 6000;
      end
      hi = (hi > 99) ? 99 : hi;
      if (tb == 0) return hi * 100 + ((lo > 99) ? 99 : lo);
      lo = (lo > 59) ? 59 : lo;
      return (tb == 1) ? (hi * 60 + lo) * 100 : (hi * 60 + lo) * 6000;
   endfunction : preset
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr_next
   // Reference prescaler: one tick pulse every TC cycles after reset
   always @(posedge ref_clk) begin
      exp_tick <= !rst && pc == TC - 1;
      pc       <= (rst || pc == TC - 1) ? 0 : pc + 1;
   end
   always @(negedge ref_clk) begin
      if (!rst) chk(tick === exp_tick, "tick out of step");
   end
   task automatic chk(input logic ok, input string msg);
      checked++;
      if (!ok) begin
         fail_count++;
         $display("[ERR] %0t %s", $time, msg);
      end
   endtask : chk
   task automatic cyc(input int k);
      repeat (k) @(posedge ref_clk);
   endtask : cyc
   // Waits for q to reach lvl, counting falling edges in n
   task automatic wait_q(input logic lvl, input int lim);
      n = 0;
      @(negedge ref_clk);
      while (q !== lvl && n < lim) begin
         @(negedge ref_clk);
         n++;
      end
   endtask : wait_q
   task automatic run_on(input int p);
      @(posedge ref_clk);
      trg <= 1'b1;
      wait_q(1'b1, p * TC + 20);
      // Prescaler free-runs, so the first tick may come early
      chk(q === 1'b1 && elapsed_count >= 32'(p) && elapsed_count <= 32'(p + 1)
          && n + 2 * TC >= p * TC, "on-delay expiry");
      @(posedge ref_clk);
      trg <= 1'b0;
      cyc(2);
      @(negedge ref_clk);
      chk(q === 1'b0, "output high with trigger low");
      @(posedge ref_clk);
   endtask : run_on
   task automatic tally_and_finish;
      $display("checked %0d fail_count %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : tally_and_finish
   initial begin
      #(40 * 90000);
      fail_count++;
      tally_and_finish();
   end
   initial begin
      {rst, restart, off_mode, retentive, trg, tmr_reset, use_ref} = 7'h40;
      {timebase, par_hi, par_lo, src_val} = '0;
      lfsr = 32'h5417;
      cyc(8);
      rst <= 1'b0;
      for (int i = 0; i < 8; i++) begin
         lfsr = lfsr_next(lfsr);
         if (i == 0) c_lo[0] = int'(lfsr[4:0]);
         use_ref <= c_r[i][0];
         timebase <= 2'(c_tb[i]);
         par_hi <= 16'(c_hi[i]);
         par_lo <= 16'(c_lo[i]);
         src_val <= 32'(c_v[i]);
         cyc(3);
         run_on(preset(c_r[i], c_tb[i], c_hi[i], c_lo[i], c_v[i]));
      end
      {use_ref, timebase, par_lo} <= {1'b0, 2'h0, 16'h0014};
      cyc(2);
      trg <= 1'b1;
      cyc(5 * TC);
      trg <= 1'b0;
      cyc(1);
      @(negedge ref_clk);
      chk(q === 1'b0 && elapsed_count === 32'h0, "early fall not cleared");
      run_on(20);
      off_mode <= 1'b1;
      par_lo <= 16'h000a;
      cyc(2);
      trg <= 1'b1;
      @(negedge ref_clk);
      @(negedge ref_clk);
      chk(q === 1'b1, "off-delay output not immediate");
      cyc(5);
      trg <= 1'b0;
      cyc(1);
      @(negedge ref_clk);
      chk(q === 1'b1 && elapsed_count === 32'h0, "fall did not restart");
      cyc(6 * TC);
      trg <= 1'b1;
      cyc(1);
      trg <= 1'b0;
      wait_q(1'b0, 20 * TC);
      chk(q === 1'b0 && n + 2 * TC >= 10 * TC, "off-delay expiry");
      @(posedge ref_clk);
      trg <= 1'b1;
      cyc(2);
      trg <= 1'b0;
      cyc(3 * TC);
      tmr_reset <= 1'b1;
      cyc(1);
      tmr_reset <= 1'b0;
      cyc(1);
      @(negedge ref_clk);
      chk(q === 1'b0 && elapsed_count === 32'h0, "reset input ignored");
      @(posedge ref_clk);
      trg <= 1'b1;
      cyc(2);
      trg <= 1'b0;
      {retentive, restart} <= 2'b11;
      cyc(1);
      restart <= 1'b0;
      cyc(1);
      @(negedge ref_clk);
      chk(q === 1'b1, "retentive state lost");
      @(posedge ref_clk);
      {retentive, restart} <= 2'b01;
      cyc(1);
      restart <= 1'b0;
      cyc(1);
      @(negedge ref_clk);
      chk(q === 1'b0 && elapsed_count === 32'h0, "restart did not clear");
      tally_and_finish();
   end
endmodule : on_off_delay_timers_tb
